// ---- logic/i2c_target_pkg.sv ----
package i2c_target_pkg;
  // Upper six address bits after reset
  localparam logic [5:0] ADDR_HI_RESET = 6'h0f;
  // Angular rate output window, pointer wraps low to high
  localparam logic [7:0] RATE_LO = 8'h0c;
  localparam logic [7:0] RATE_HI = 8'h11;
  // Bits per byte on the wire
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Bus frame states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_AACK = 6'b000100,
    ST_RECV = 6'b001000,
    ST_SEND = 6'b010000,
    ST_CACK = 6'b100000
  } frame_state_t;
endpackage : i2c_target_pkg

// ---- logic/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous inputs and their synchronised copies
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;

  // Two flops; stage1 feeds only sync_out. Idle bus level is high
  always_comb begin
    next_stage1 = async_in;
    next_sync = stage1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= '1;
      sync_out <= '1;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync;
    end
  end
endmodule : pin_sync
`default_nettype wire

// ---- logic/i2c_register_access_slave.sv ----
// How it works
// - Byte after write address byte is stored as the register pointer.
// - Read returns the register selected by the earlier pointer byte.
// - First byte is seven address bits then direction, zero write.
// - Single read: pointer write, repeated start, read address, data, nack, stop.
// - Single write: address, pointer, data, each target acknowledged, stop.
// - Pointing at a rate output register requests a fresh measurement.
// - Pointer decrements after each read, wrapping from low to high rate register.
// - Address LSB follows the MISO pin, upper six from a stored field.
`timescale 1ns/1ps
`default_nettype none
module i2c_register_access_slave
  import i2c_target_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus pins, open drain data
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address strap and stored field
  input wire logic miso_in,
  input wire logic [5:0] addr_hi,
  // Register file port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  input wire logic [7:0] reg_rdata,
  output logic rate_refresh
);
  logic scl;
  logic sda;
  logic miso;
  logic scl_d;
  logic sda_d;
  frame_state_t state;
  frame_state_t next_state;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic is_read;
  logic next_is_read;
  logic ptr_phase;
  logic next_ptr_phase;
  logic drive_low;
  logic next_drive_low;
  logic [7:0] next_reg_addr;
  logic [7:0] next_reg_wdata;
  logic next_reg_we;
  logic next_rate_refresh;
  logic [6:0] own_addr;
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;

  pin_sync #(.WIDTH(3)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({scl_in, sda_in, miso_in}),
    .sync_out({scl, sda, miso})
  );

  // Bus event detection on synchronised levels
  always_comb begin
    start_cond = scl && scl_d && sda_d && !sda;
    stop_cond = scl && scl_d && !sda_d && sda;
    scl_rise = scl && !scl_d;
    scl_fall = !scl && scl_d;
    own_addr = {addr_hi, miso};
  end

  // Open drain: only ever pull low
  always_comb begin
    sda_out = 1'b0;
    sda_oe = drive_low;
  end

  // Frame sequencer
  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_is_read = is_read;
    next_ptr_phase = ptr_phase;
    next_drive_low = drive_low;
    next_reg_addr = reg_addr;
    next_reg_wdata = reg_wdata;
    next_reg_we = 1'b0;
    next_rate_refresh = 1'b0;
    if (start_cond) begin
      // Repeated start keeps the pointer for the read phase
      next_state = ST_ADDR;
      next_bitcnt = '0;
      next_drive_low = 1'b0;
    end else if (stop_cond) begin
      next_state = ST_IDLE;
      next_drive_low = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_drive_low = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == BYTE_BITS) begin
            next_bitcnt = '0;
            if (shreg[7:1] == own_addr) begin
              next_is_read = shreg[0];
              next_ptr_phase = !shreg[0];
              next_drive_low = 1'b1;
              next_state = ST_AACK;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          // Ack clock ends; reads load data, writes release the line
          if (scl_fall) begin
            if (is_read) begin
              next_shreg = reg_rdata;
              next_drive_low = !reg_rdata[7];
              next_bitcnt = 4'h1;
              next_state = ST_SEND;
            end else begin
              next_drive_low = 1'b0;
              next_state = ST_RECV;
            end
          end
        end
        ST_RECV: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == BYTE_BITS) begin
            next_bitcnt = '0;
            next_drive_low = 1'b1;
            next_state = ST_AACK;
            if (ptr_phase) begin
              next_reg_addr = shreg;
              next_ptr_phase = 1'b0;
              next_rate_refresh = shreg >= RATE_LO && shreg <= RATE_HI;
            end else begin
              next_reg_wdata = shreg;
              next_reg_we = 1'b1;
            end
          end
        end
        ST_SEND: begin
          // Shift out MSB first, change data while clock is low
          if (scl_fall) begin
            if (bitcnt == BYTE_BITS) begin
              next_drive_low = 1'b0;
              next_bitcnt = '0;
              next_state = ST_CACK;
              next_reg_addr = (reg_addr == RATE_LO) ? RATE_HI : reg_addr - 8'h01;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_drive_low = !shreg[6];
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        ST_CACK: begin
          // Controller ack continues, a nack ends the burst
          if (scl_rise) begin
            next_is_read = !sda;
          end else if (scl_fall) begin
            if (is_read) begin
              next_shreg = reg_rdata;
              next_drive_low = !reg_rdata[7];
              next_bitcnt = 4'h1;
              next_state = ST_SEND;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      bitcnt <= '0;
      shreg <= '0;
      is_read <= 1'b0;
      ptr_phase <= 1'b0;
      drive_low <= 1'b0;
      reg_addr <= '0;
      reg_wdata <= '0;
      reg_we <= 1'b0;
      rate_refresh <= 1'b0;
    end else begin
      state <= next_state;
      scl_d <= scl;
      sda_d <= sda;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      is_read <= next_is_read;
      ptr_phase <= next_ptr_phase;
      drive_low <= next_drive_low;
      reg_addr <= next_reg_addr;
      reg_wdata <= next_reg_wdata;
      reg_we <= next_reg_we;
      rate_refresh <= next_rate_refresh;
    end
  end

  // Checks
  wrap_pointer_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_SEND && scl_fall && bitcnt == BYTE_BITS && reg_addr == RATE_LO) |=> reg_addr == RATE_HI)
    else $error("pointer did not wrap");
  dec_pointer_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_SEND && scl_fall && bitcnt == BYTE_BITS && reg_addr != RATE_LO && !start_cond && !stop_cond)
    |=> reg_addr == $past(reg_addr) - 8'h01)
    else $error("pointer did not decrement");
  mismatch_idle_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_ADDR && scl_fall && bitcnt == BYTE_BITS && shreg[7:1] != own_addr && !start_cond && !stop_cond)
    |=> state == ST_IDLE && !sda_oe)
    else $error("mismatch acknowledged");
  match_ack_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_ADDR && scl_fall && bitcnt == BYTE_BITS && shreg[7:1] == own_addr && !start_cond && !stop_cond)
    |=> sda_oe && is_read == $past(shreg[0]))
    else $error("address not acknowledged");
  refresh_range_a: assert property (@(posedge clk) disable iff (rst)
    rate_refresh |-> reg_addr >= RATE_LO && reg_addr <= RATE_HI)
    else $error("refresh outside rate window");
  write_pulse_a: assert property (@(posedge clk) disable iff (rst)
    reg_we |-> !rate_refresh ##1 !reg_we)
    else $error("write strobe too long");
  idle_release_a: assert property (@(posedge clk) disable iff (rst)
    state == ST_IDLE |=> !sda_oe)
    else $error("line held while idle");
  send_msb_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_AACK && is_read && scl_fall && !start_cond && !stop_cond) |=> sda_oe == !$past(reg_rdata[7]))
    else $error("wrong first data bit");
  cov_write_c: cover property (@(posedge clk) reg_we);
  cov_refresh_c: cover property (@(posedge clk) rate_refresh);
  cov_read_c: cover property (@(posedge clk) state == ST_CACK);
  cov_wrap_c: cover property (@(posedge clk) state == ST_SEND && scl_fall && bitcnt == BYTE_BITS && reg_addr == RATE_LO);
endmodule : i2c_register_access_slave
`default_nettype wire

// ---- dv/i2c_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
  // Clock
  input wire logic clk,
  // Bus clock and data pull-down, resolved data level
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // Clock stands still high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_n
  // Data moves only mid-low, so the target never sees a false start or stop
  task automatic bit_cell(input logic b, output logic seen);
    wait_n(4);
    sda_low <= ~b;
    wait_n(4);
    scl <= 1'b1;
    wait_n(8);
    seen = sda;
    scl <= 1'b0;
  endtask : bit_cell
  // Start and repeated start: data falls while the clock is high
  task automatic start();
    wait_n(4);
    sda_low <= 1'b0;
    wait_n(4);
    scl <= 1'b1;
    wait_n(8);
    sda_low <= 1'b1;
    wait_n(8);
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    wait_n(4);
    sda_low <= 1'b1;
    wait_n(4);
    scl <= 1'b1;
    wait_n(8);
    sda_low <= 1'b0;
    wait_n(8);
  endtask : stop
  // MSB first, then the ninth cell released for the target's answer
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cell(d[i], s);
    end
    bit_cell(1'b1, s);
    ack = ~s;
  endtask : wbyte
  // Controller answers every returned byte, low unless it is the last
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cell(1'b1, d[i]);
    end
    bit_cell(last, s);
  endtask : rbyte
endmodule : i2c_ctrl_model
`default_nettype wire

// ---- dv/i2c_register_access_slave_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module i2c_register_access_slave_tb_top
  import i2c_target_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic miso_in = 1'b1;
  logic [5:0] addr_hi = ADDR_HI_RESET;
  logic scl, sda_low, sda, sda_out, sda_oe, reg_we, rate_refresh;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [7:0] mem [0:31];
  int error_cnt = 0;
  int samples_checked = 0;
  int we_seen = 0;
  int rr_seen = 0;
  always #4 clk = ~clk;
  // Open-drain wire with pull-up
  assign sda = ~(sda_low | (sda_oe & ~sda_out));
  assign reg_rdata = mem[reg_addr[4:0]];
  // Register file stand-in; counts pulses for the scenarios
  always @(posedge clk) begin
    if (reg_we === 1'b1) begin
      mem[reg_addr[4:0]] <= reg_wdata;
      we_seen++;
    end
    if (rate_refresh === 1'b1) rr_seen++;
  end
  i2c_ctrl_model i_ctl (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
  i2c_register_access_slave i_dut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .miso_in(miso_in), .addr_hi(addr_hi),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata),
    .rate_refresh(rate_refresh));
  task automatic tally_and_finish();
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // Single write to address 0x1f (strap high)
  task automatic t_write();
    logic a0, a1, a2;
    we_seen = 0;
    i_ctl.start();
    i_ctl.wbyte({ADDR_HI_RESET, 1'b1, 1'b0}, a0);
    i_ctl.wbyte(8'h02, a1);
    i_ctl.wbyte(8'ha5, a2);
    i_ctl.stop();
    `CHECK({a0, a1, a2}, 3'h7)
    `CHECK(mem[2], 8'ha5)
    `CHECK(we_seen, 32'h1)
  endtask : t_write
  // Pointer write, repeated start, two-byte read; second byte shows the pointer step (decrement, or wrap at 0x0c)
  task automatic t_read(input logic [7:0] ptr, input logic [7:0] nxt, input int rr);
    logic a0, a1, a2;
    logic [7:0] d0, d1;
    rr_seen = 0;
    i_ctl.start();
    i_ctl.wbyte({ADDR_HI_RESET, miso_in, 1'b0}, a0);
    i_ctl.wbyte(ptr, a1);
    i_ctl.start();
    i_ctl.wbyte({ADDR_HI_RESET, miso_in, 1'b1}, a2);
    i_ctl.rbyte(1'b0, d0);
    i_ctl.rbyte(1'b1, d1);
    i_ctl.stop();
    `CHECK({a0, a1, a2}, 3'h7)
    `CHECK(d0, mem[ptr[4:0]])
    `CHECK(d1, mem[nxt[4:0]])
    `CHECK(rr_seen, rr)
  endtask : t_read
  // Foreign address: no answer, no write, no refresh
  task automatic t_foreign();
    logic a0, a1;
    we_seen = 0;
    rr_seen = 0;
    i_ctl.start();
    i_ctl.wbyte({ADDR_HI_RESET ^ 6'h01, miso_in, 1'b0}, a0);
    i_ctl.wbyte(8'h0d, a1);
    i_ctl.stop();
    `CHECK({a0, a1}, 2'h0)
    `CHECK(we_seen + rr_seen, 32'h0)
  endtask : t_foreign
  // One decrementing burst over every rate register, wrapping once; a single refresh serves it all
  task automatic t_burst();
    logic a0, a1, a2;
    logic [7:0] d;
    logic [55:0] seq = {8'h0d, 8'h0c, 8'h11, 8'h10, 8'h0f, 8'h0e, 8'h0d};
    rr_seen = 0;
    i_ctl.start();
    i_ctl.wbyte({ADDR_HI_RESET, miso_in, 1'b0}, a0);
    i_ctl.wbyte(8'h0d, a1);
    i_ctl.start();
    i_ctl.wbyte({ADDR_HI_RESET, miso_in, 1'b1}, a2);
    `CHECK({a0, a1, a2}, 3'h7)
    for (int i = 0; i < 7; i++) begin
      i_ctl.rbyte(i == 6, d);
      `CHECK(d, mem[seq[48 - 8 * i +: 5]])
    end
    i_ctl.stop();
    `CHECK(rr_seen, 32'h1)
  endtask : t_burst
  // A new stored field moves the address; the old one is foreign from then on
  task automatic t_stored();
    logic a0, a1, a2, b0;
    addr_hi <= 6'h2a;
    i_ctl.start();
    i_ctl.wbyte({6'h2a, miso_in, 1'b0}, a0);
    i_ctl.wbyte(8'h03, a1);
    i_ctl.wbyte(8'h3c, a2);
    i_ctl.stop();
    i_ctl.start();
    i_ctl.wbyte({ADDR_HI_RESET, miso_in, 1'b0}, b0);
    i_ctl.stop();
    addr_hi <= ADDR_HI_RESET;
    `CHECK({a0, a1, a2, b0}, 4'he)
    `CHECK(mem[3], 8'h3c)
  endtask : t_stored
  // Watchdog against a hung run
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    for (int i = 0; i < 32; i++) mem[i] = 8'h5a ^ 8'(i * 7);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_write();
    t_read(8'h11, 8'h10, 1);
    t_read(8'h0c, 8'h11, 1);
    miso_in <= 1'b0;
    t_read(8'h02, 8'h01, 0);
    t_foreign();
    t_burst();
    t_stored();
    tally_and_finish();
  end
endmodule : i2c_register_access_slave_tb_top
`default_nettype wire
